// [lms_defines.vh]
// constants for the loop maintenance and status led block
`ifndef LMS_DEFINES_VH
`define LMS_DEFINES_VH
`define LMS_CLK_MHZ 200
`define LMS_TICK_US 500
`define LMS_TICK_CYC (`LMS_TICK_US * `LMS_CLK_MHZ)
`define LMS_FILTER_MS 20
`define LMS_FILTER_TICKS (`LMS_FILTER_MS * 1000 / `LMS_TICK_US)
`define LMS_GAP_MS 200
`define LMS_GAP_TICKS (`LMS_GAP_MS * 1000 / `LMS_TICK_US)
`define LMS_ATTEMPT_MS 500
`define LMS_ATTEMPT_TICKS (`LMS_ATTEMPT_MS * 1000 / `LMS_TICK_US)
`define LMS_FOL_MS 1000
`define LMS_FOL_TICKS (`LMS_FOL_MS * 1000 / `LMS_TICK_US)
`define LMS_HALF8_US 62500
`define LMS_HALF8_TICKS (`LMS_HALF8_US / `LMS_TICK_US)
`define LMS_ADDR_GCR 5'h00
`define LMS_ADDR_CFR 5'h06
`define LMS_ADDR_STAT 5'h07
`define LMS_ADDR_MIR 5'h0F
`define LMS_ADDR_MIM 5'h10
`define LMS_GCR_AUTO_BIT 3
`define LMS_GCR_AADIS_BIT 6
`define LMS_GCR_RESET 8'h08
`define LMS_CFR_TONE_BIT 0
`define LMS_CFR_LOOP_BIT 1
`define LMS_MIR_DECODE_BIT 0
`define LMS_MIR_LEVEL_BIT 1
`define LMS_MIR_RESET 8'h00
`define LMS_MIM_RESET 8'h00
`define LMS_CODE_TONE 3'h1
`define LMS_CODE_LOOP 3'h2
`endif

// [lms_top.v]
// loop maintenance pulse decoding, test tone control and status led
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "lms_defines.vh"

module lms_top #(
    parameter TICK_CYC = `LMS_TICK_CYC,
    parameter CODE_W = 3
) (
    // clock and reset
    input wire i_mclk,
    input wire i_rstn,
    // register port
    input wire [4:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [7:0] o_rdata,
    // pins and line status
    input wire i_maintenance_pulse_in,
    input wire i_insertion_loss_test_n,
    input wire i_sck_strap,
    input wire i_line_active,
    // outputs
    output reg o_status_led_out,
    output reg o_single_test_tone,
    output reg o_loopback,
    output reg o_activation_attempt,
    output reg o_irq
);

    localparam P_STRAP = 4'h1;
    localparam P_ATTEMPT = 4'h2;
    localparam P_FOL = 4'h4;
    localparam P_RUN = 4'h8;

    localparam [1:0] LED_LOW = 2'h0;
    localparam [1:0] LED_HIGH = 2'h1;
    localparam [1:0] LED_1HZ = 2'h2;
    localparam [1:0] LED_8HZ = 2'h3;

    // shared tick timebase
    reg [31:0] tick_cnt_q;
    reg tick_q;
    always @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            tick_cnt_q <= 32'h0;
            tick_q <= 1'b0;
        end
        else if (tick_cnt_q == TICK_CYC - 1)
        begin
            tick_cnt_q <= 32'h0;
            tick_q <= 1'b1;
        end
        else
        begin
            tick_cnt_q <= tick_cnt_q + 32'h1;
            tick_q <= 1'b0;
        end
    end

    // pulse filter: a new level must stand a whole window to be taken
    reg filt_q;
    reg [15:0] filt_cnt_q;
    reg lvl_evt_q;
    always @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            filt_q <= 1'b1;
            filt_cnt_q <= 16'h0;
            lvl_evt_q <= 1'b0;
        end
        else
        begin
            lvl_evt_q <= 1'b0;
            if (i_maintenance_pulse_in == filt_q)
                filt_cnt_q <= 16'h0;
            else if (tick_q)
            begin
                if (filt_cnt_q == `LMS_FILTER_TICKS - 1)
                begin
                    filt_q <= i_maintenance_pulse_in;
                    filt_cnt_q <= 16'h0;
                    lvl_evt_q <= 1'b1;
                end
                else
                    filt_cnt_q <= filt_cnt_q + 16'h1;
            end
        end
    end

    // decoder: count filtered low pulses, latch after an idle gap
    reg filt_d1_q;
    reg [CODE_W-1:0] pcnt_q;
    reg [CODE_W-1:0] code_q;
    reg [15:0] gap_q;
    reg dec_evt_q;
    always @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            filt_d1_q <= 1'b1;
            pcnt_q <= {CODE_W{1'b0}};
            code_q <= {CODE_W{1'b0}};
            gap_q <= 16'h0;
            dec_evt_q <= 1'b0;
        end
        else
        begin
            filt_d1_q <= filt_q;
            dec_evt_q <= 1'b0;
            if (filt_d1_q && !filt_q)
            begin
                if (pcnt_q != {CODE_W{1'b1}})
                    pcnt_q <= pcnt_q + {{(CODE_W-1){1'b0}}, 1'b1};
                gap_q <= 16'h0;
            end
            else if (!filt_q)
                gap_q <= 16'h0;
            else if (tick_q && pcnt_q != {CODE_W{1'b0}})
            begin
                if (gap_q == `LMS_GAP_TICKS - 1)
                begin
                    code_q <= pcnt_q;
                    dec_evt_q <= 1'b1;
                    pcnt_q <= {CODE_W{1'b0}};
                    gap_q <= 16'h0;
                end
                else
                    gap_q <= gap_q + 16'h1;
            end
        end
    end

    // registers
    reg [7:0] gcr_q;
    reg [7:0] cfr_q;
    reg [7:0] mir_q;
    reg [7:0] mim_q;
    reg [7:0] mir_d;
    wire auto_maintenance_ctl;
    wire [7:0] evt;
    assign auto_maintenance_ctl = gcr_q[`LMS_GCR_AUTO_BIT];
    assign evt = {6'h0, lvl_evt_q, dec_evt_q};

    always @*
    begin
        mir_d = mir_q;
        if (i_wr && i_addr == `LMS_ADDR_MIR)
            mir_d = mir_d & ~i_wdata;
        // a new event wins over a clear in the same cycle
        mir_d = mir_d | evt;
    end

    reg [3:0] phase_q;
    always @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            gcr_q <= `LMS_GCR_RESET;
            cfr_q <= 8'h00;
            mir_q <= `LMS_MIR_RESET;
            mim_q <= `LMS_MIM_RESET;
        end
        else
        begin
            mir_q <= mir_d;
            if (phase_q == P_STRAP && i_sck_strap)
                gcr_q[`LMS_GCR_AADIS_BIT] <= 1'b1;
            else if (i_wr && i_addr == `LMS_ADDR_GCR)
                gcr_q <= i_wdata;
            if (i_wr && i_addr == `LMS_ADDR_CFR)
                cfr_q <= i_wdata;
            if (i_wr && i_addr == `LMS_ADDR_MIM)
                mim_q <= i_wdata;
        end
    end

    // start-up sequence; strap is caught on the first edge after release
    reg [15:0] ph_cnt_q;
    always @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            phase_q <= P_STRAP;
            ph_cnt_q <= 16'h0;
        end
        else
        begin
            case (phase_q)
                P_STRAP:
                begin
                    ph_cnt_q <= 16'h0;
                    phase_q <= i_sck_strap ? P_FOL : P_ATTEMPT;
                end
                P_ATTEMPT:
                begin
                    if (tick_q)
                        ph_cnt_q <= ph_cnt_q + 16'h1;
                    if (tick_q && ph_cnt_q == `LMS_ATTEMPT_TICKS - 1)
                        phase_q <= P_RUN;
                end
                P_FOL:
                begin
                    if (tick_q)
                        ph_cnt_q <= ph_cnt_q + 16'h1;
                    if (tick_q && ph_cnt_q == `LMS_FOL_TICKS - 1)
                        phase_q <= P_RUN;
                end
                P_RUN:
                    ph_cnt_q <= 16'h0;
                default:
                    phase_q <= P_STRAP;
            endcase
        end
    end

    // flash generator: 8 Hz half period, 1 Hz from eight of those
    reg [7:0] half_cnt_q;
    reg [2:0] div_q;
    reg f8_q;
    reg f1_q;
    always @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            half_cnt_q <= 8'h0;
            div_q <= 3'h0;
            f8_q <= 1'b0;
            f1_q <= 1'b0;
        end
        else if (tick_q)
        begin
            if (half_cnt_q == `LMS_HALF8_TICKS - 1)
            begin
                half_cnt_q <= 8'h0;
                f8_q <= ~f8_q;
                div_q <= div_q + 3'h1;
                if (div_q == 3'h7)
                    f1_q <= ~f1_q;
            end
            else
                half_cnt_q <= half_cnt_q + 8'h1;
        end
    end

    reg [1:0] led_mode;
    always @*
    begin
        case (phase_q)
            P_ATTEMPT: led_mode = LED_8HZ;
            P_FOL: led_mode = LED_LOW;
            P_RUN:
            begin
                if (i_line_active)
                    led_mode = LED_1HZ;
                else if (!gcr_q[`LMS_GCR_AADIS_BIT])
                    led_mode = LED_8HZ;
                else
                    led_mode = LED_HIGH;
            end
            default: led_mode = LED_HIGH;
        endcase
    end

    // outputs, all registered
    always @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_status_led_out <= 1'b1;
            o_single_test_tone <= 1'b0;
            o_loopback <= 1'b0;
            o_activation_attempt <= 1'b0;
            o_irq <= 1'b0;
            o_rdata <= 8'h00;
        end
        else
        begin
            case (led_mode)
                LED_LOW: o_status_led_out <= 1'b0;
                LED_HIGH: o_status_led_out <= 1'b1;
                LED_1HZ: o_status_led_out <= f1_q;
                default: o_status_led_out <= f8_q;
            endcase
            if (auto_maintenance_ctl)
            begin
                // pin and decoder both request the tone; the pin can raise it during loopback
                o_single_test_tone <= !i_insertion_loss_test_n
                    || code_q == `LMS_CODE_TONE;
                o_loopback <= code_q == `LMS_CODE_LOOP;
            end
            else
            begin
                o_single_test_tone <= cfr_q[`LMS_CFR_TONE_BIT];
                o_loopback <= cfr_q[`LMS_CFR_LOOP_BIT];
            end
            o_activation_attempt <= phase_q != P_STRAP
                && phase_q != P_FOL && !gcr_q[`LMS_GCR_AADIS_BIT];
            o_irq <= |(mir_d & mim_q);
            o_rdata <= 8'h00;
            if (i_rd)
            begin
                case (i_addr)
                    `LMS_ADDR_GCR: o_rdata <= gcr_q;
                    `LMS_ADDR_CFR: o_rdata <= cfr_q;
                    `LMS_ADDR_STAT: o_rdata <= {o_status_led_out,
                        filt_q, phase_q[3], i_line_active, 1'b0,
                        code_q};
                    `LMS_ADDR_MIR: o_rdata <= mir_q;
                    `LMS_ADDR_MIM: o_rdata <= mim_q;
                    default: o_rdata <= 8'h00;
                endcase
            end
        end
    end

endmodule // lms_top
`default_nettype wire

// [lms_opto.sv]
// optoisolator model driving maintenance pulse trains
`timescale 1ns/1ps
`default_nettype none
module lms_opto (
    input wire logic i_clk,
    input wire logic [2:0] i_count,
    input wire logic [15:0] i_half,
    input wire logic i_go,
    output logic o_line,
    output logic o_busy
);
    // idles high as the pull-up would; busy stays low meanwhile
    initial o_line = 1'b1;
    initial o_busy = 1'b0;
    always @(posedge i_clk)
    begin
        if (i_go)
        begin
            o_busy <= 1'b1;
            repeat (i_count)
            begin
                o_line <= 1'b0;
                repeat (i_half) @(posedge i_clk);
                o_line <= 1'b1;
                repeat (i_half) @(posedge i_clk);
            end
            o_busy <= 1'b0;
        end
    end
endmodule // lms_opto
`default_nettype wire

// [lms_chk_asserts.sv]
// assertions for the loop maintenance and status led block
`timescale 1ns/1ps
`default_nettype none
module lms_chk #(
    parameter TICK_CYC = 10
) (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic [4:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic i_insertion_loss_test_n,
    input wire logic i_sck_strap,
    input wire logic o_status_led_out,
    input wire logic o_single_test_tone,
    input wire logic o_loopback,
    input wire logic o_activation_attempt,
    input wire logic o_irq
);
    localparam int FOL = 2000 * TICK_CYC;
    logic auto_q, cfr_q, strap_q;
    int cnt_q;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    always @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            auto_q <= 1'b1;
            cfr_q <= 1'b0;
            strap_q <= 1'b0;
            cnt_q <= 0;
        end
        else
        begin
            if (i_wr && i_addr == 5'h00)
                auto_q <= i_wdata[3];
            if (i_wr && i_addr == 5'h06)
                cfr_q <= i_wdata[0];
            if (cnt_q == 0)
                strap_q <= i_sck_strap;
            if (cnt_q < FOL)
                cnt_q <= cnt_q + 1;
        end
    end
    sequence s_cfr_wr;
        i_wr && i_addr == 5'h06 && !auto_q ##1 !(i_wr && i_addr == 5'h00);
    endsequence
    // margins allow for the tick phase at strap capture
    sequence s_fol;
        strap_q && cnt_q > 4 && cnt_q < FOL - 2 * TICK_CYC;
    endsequence
    a_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
        else $error("read data not idle");
    a_unmapped_zero: assert property (
        i_rd && i_addr == 5'h1F |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_irq_masked: assert property (
        i_wr && i_addr == 5'h10 && i_wdata == 8'h00 ##1 !i_wr |=> !o_irq)
        else $error("masked interrupt high");
    a_tone_pin: assert property (
        (auto_q && !i_insertion_loss_test_n) [*6] |-> o_single_test_tone)
        else $error("tone pin not obeyed");
    a_pin_ignored: assert property (
        (!auto_q && !cfr_q) [*4] |-> !o_single_test_tone)
        else $error("tone sent with bit clear");
    a_manual_cfr: assert property (s_cfr_wr |=>
        o_single_test_tone == $past(i_wdata[0], 2) &&
        o_loopback == $past(i_wdata[1], 2))
        else $error("control bits not applied");
    a_strap_led: assert property (s_fol |-> !o_status_led_out)
        else $error("led not low after reset");
    a_no_attempt: assert property (
        strap_q && cnt_q > 4 |-> !o_activation_attempt)
        else $error("activation attempted");
endmodule // lms_chk
bind lms_top lms_chk #(.TICK_CYC(TICK_CYC)) u_chk (.i_mclk(i_mclk),
    .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata),
    .i_insertion_loss_test_n(i_insertion_loss_test_n),
    .i_sck_strap(i_sck_strap), .o_status_led_out(o_status_led_out),
    .o_single_test_tone(o_single_test_tone), .o_loopback(o_loopback),
    .o_activation_attempt(o_activation_attempt), .o_irq(o_irq));
`default_nettype wire

// [tb.sv]
// testbench for the loop maintenance and status led block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, go = 1'b0;
    logic ls_n = 1'b1, strap = 1'b0, line = 1'b0;
    logic [4:0] addr = 5'h00;
    logic [7:0] wdata = 8'h00, rdata, v;
    logic [2:0] cnt = 3'h0;
    logic [15:0] half = 16'h0000;
    wire pls, busy, led, tone, loop, att, irq;
    int err_count = 0, samples_checked = 0, cyc = 0;
    always #2.5 clk = ~clk;
    lms_top #(.TICK_CYC(10)) DUT (.i_mclk(clk), .i_rstn(rstn),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_maintenance_pulse_in(pls),
        .i_insertion_loss_test_n(ls_n), .i_sck_strap(strap),
        .i_line_active(line), .o_status_led_out(led),
        .o_single_test_tone(tone), .o_loopback(loop),
        .o_activation_attempt(att), .o_irq(irq));
    lms_opto opto (.i_clk(clk), .i_count(cnt), .i_half(half), .i_go(go),
        .o_line(pls), .o_busy(busy));
    task final_report;
        begin
            $display("checks %0d mismatches %0d", samples_checked, err_count);
            if (err_count == 0 && samples_checked > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    task chk(input string n, input logic [15:0] e, input logic [15:0] s);
        begin
            samples_checked++;
            if (s !== e)
            begin
                err_count++;
                $display("unexpected %s expected %h seen %h", n, e, s);
            end
        end
    endtask
    task wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    task wrr(input logic [4:0] a, input logic [7:0] d);
        begin
            @(posedge clk);
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
        end
    endtask
    task rdd(input logic [4:0] a);
        begin
            @(posedge clk);
            addr <= a;
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            @(negedge clk);
            v = rdata;
        end
    endtask
    // waits out busy, the filter and the decode gap
    task send(input logic [2:0] c, input logic [15:0] h);
        begin
            @(posedge clk);
            cnt <= c;
            half <= h;
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            wt(2);
            while (busy === 1'b1) @(negedge clk);
            wt(4700);
        end
    endtask
    // lets a led mode switch settle first, so a switch-over step
    // is not taken for a flash edge; then counts one whole half period
    task gap(input logic [15:0] e);
        logic l;
        int n;
        begin
            wt(2);
            for (int k = 0; k < 2; k++)
            begin
                l = led;
                n = 0;
                while (led === l && n < 30000)
                begin
                    @(negedge clk);
                    n++;
                end
            end
            chk("led", e, n[15:0]);
        end
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            err_count++;
            final_report;
        end
    end
    initial
    begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rdd(5'h00);
        chk("gcr", 16'h0008, v);
        rdd(5'h1F);
        chk("hole", 16'h0000, v);
        gap(16'h04E2);
        chk("att", 16'h0001, att);
        $display("test startup done");
        @(posedge clk) ls_n <= 1'b0;
        wt(8);
        chk("tone", 16'h0001, tone);
        @(posedge clk) ls_n <= 1'b1;
        wt(8);
        chk("tone", 16'h0000, tone);
        wrr(5'h00, 8'h00);
        @(posedge clk) ls_n <= 1'b0;
        wt(8);
        chk("tone", 16'h0000, tone);
        wrr(5'h06, 8'h01);
        wt(3);
        chk("tone", 16'h0001, tone);
        wrr(5'h06, 8'h00);
        @(posedge clk) ls_n <= 1'b1;
        wrr(5'h00, 8'h08);
        $display("test tone done");
        wrr(5'h10, 8'h01);
        send(3'h1, 16'h0258);
        rdd(5'h07);
        chk("code", 16'h0001, v[2:0]);
        rdd(5'h0F);
        chk("mir", 16'h0003, v);
        chk("tone", 16'h0001, tone);
        chk("irq", 16'h0001, irq);
        wrr(5'h10, 8'h00);
        wt(3);
        chk("irq", 16'h0000, irq);
        wrr(5'h0F, 8'hFF);
        wrr(5'h10, 8'h01);
        wt(3);
        chk("irq", 16'h0000, irq);
        send(3'h1, 16'h012C);
        rdd(5'h0F);
        chk("mir", 16'h0000, v);
        send(3'h2, 16'h0258);
        chk("loop", 16'h0001, loop);
        chk("tone", 16'h0000, tone);
        wrr(5'h00, 8'h00);
        wrr(5'h0F, 8'hFF);
        send(3'h1, 16'h0258);
        rdd(5'h0F);
        chk("mir", 16'h0003, v);
        chk("tone", 16'h0000, tone);
        $display("test decode done");
        @(posedge clk) line <= 1'b1;
        gap(16'h2710);
        $display("test line done");
        @(posedge clk) strap <= 1'b1;
        line <= 1'b0;
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        wt(1000);
        chk("led", 16'h0000, led);
        chk("att", 16'h0000, att);
        rdd(5'h00);
        chk("gcr", 16'h0048, v);
        wt(20500);
        chk("led", 16'h0001, led);
        $display("test strap done");
        final_report;
    end
endmodule // tb
`default_nettype wire
